// *** hdl/pdmc_ctrl.sv ***
// Summary of operation
// - 8-bit standby register, cleared on reset, hw-standby
// - Bit 4 halts the wide timer
// - Bit 3 halts byte timer pair A
// - Bit 2 halts byte timer pair B
// - Bit 0 halts the converter
// - Reserved bits store and read back only
// - Sleep with select low halts CPU
// - Peripherals run in sleep unless halted
// - Unmasked interrupt ends sleep
// - Init pin low in sleep resets
// - Power-down pin low in sleep: hw standby
// - Sleep with select high: software standby
// - NMI or IRQ0-2 wakes after settling wait
// - Disabled or masked IRQs do not wake
// - Init pin low restarts clocks immediately
// - Power-down pin in standby: hw standby
// - Settle code picks base wait, 111 illegal
// - Each divider step doubles the wait
// - Halt starts the cycle after the write
// - Halted module reads ones, ignores writes
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_params.svh"
module pdmc_ctrl #(
  parameter int WAIT_SCALE = 1
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  // Register port
  input  wire pdmc_pkg::pdmc_req_t  req,
  output logic [7:0]                rdata,
  // Pins
  input  wire logic                 chip_init_pin_n,
  input  wire logic                 hw_power_down_pin_n,
  // CPU side
  input  wire logic                 sleep_exec,
  input  wire logic                 nmi_req,
  input  wire logic [2:0]           irq_req,
  input  wire logic [2:0]           irq_enable,
  input  wire logic                 irq_cpu_mask,
  input  wire logic                 periph_int_req,
  output logic                      cpu_halt,
  output logic                      int_exc_start,
  output logic                      reset_exc_start,
  output logic                      clock_run,
  output logic                      periph_reset,
  // Peripheral access gating
  input  wire logic [3:0]           periph_sel,
  input  wire logic [7:0]           periph_rdata,
  output logic [7:0]                periph_rdata_gated,
  output logic                      periph_wr_block,
  // Module halts
  output pdmc_pkg::pdmc_halt_t      halt
);
  import pdmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  mstby_r;
  logic [7:0]  sysctl_r;
  logic [1:0]  clkdiv_r;
  pdmc_state_t state_r;
  pdmc_state_t state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        init_low_r;

  // Address decode
  wire sel_mstby  = req.addr == `PDMC_ADDR_MSTBY;
  wire sel_sysctl = req.addr == `PDMC_ADDR_SYSCTL;
  wire sel_clkdiv = req.addr == `PDMC_ADDR_CLKDIV;
  wire sel_status = req.addr == `PDMC_ADDR_STATUS;
  wire hw_hw_power_down_pin    = !hw_power_down_pin_n;
  wire chip_init  = !chip_init_pin_n;

  // Wake sources
  wire       ssel      = sysctl_r[`PDMC_BIT_SSEL];
  wire [2:0] sts       = sysctl_r[`PDMC_STS_HI:`PDMC_STS_LO];
  wire       irq_wake  = |(irq_req & irq_enable) && !irq_cpu_mask;
  wire       ext_wake  = nmi_req || irq_wake;
  wire       any_wake  = ext_wake || (periph_int_req && !irq_cpu_mask);

  // Base wait and divider scaling
  logic [31:0] base_wait;
  always_comb begin
    unique case (sts)
      3'h0: base_wait = `PDMC_WAIT_0;
      3'h1: base_wait = `PDMC_WAIT_1;
      3'h2: base_wait = `PDMC_WAIT_2;
      3'h3: base_wait = `PDMC_WAIT_3;
      3'h4: base_wait = `PDMC_WAIT_4;
      3'h5: base_wait = `PDMC_WAIT_5;
      3'h6: base_wait = `PDMC_WAIT_6;
      default: base_wait = `PDMC_WAIT_5;                                    // Illegal code: longest wait
    endcase
  end
  wire [31:0] wait_full = base_wait << clkdiv_r;
  wire [31:0] wait_tgt  = (WAIT_SCALE > 1) ? (wait_full / 32'(WAIT_SCALE)) : wait_full;

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      PDMC_RUN: begin
        if (sleep_exec) begin
          state_nxt = ssel ? PDMC_SWSTBY : PDMC_SLEEP;
        end
      end
      PDMC_SLEEP: begin
        if (any_wake) begin
          state_nxt = PDMC_RUN;
        end
      end
      PDMC_SWSTBY: begin
        if (ext_wake) begin
          state_nxt = PDMC_SETTLE;
          cnt_nxt   = 32'd1;
        end
      end
      PDMC_SETTLE: begin
        cnt_nxt = cnt_r + 32'd1;
        if (cnt_r >= wait_tgt) begin
          state_nxt = PDMC_RUN;
        end
      end
      PDMC_HWSTBY: begin
        state_nxt = PDMC_HWSTBY;
      end
    endcase
    if (chip_init) begin
      state_nxt = PDMC_RUN;
    end
    if (hw_hw_power_down_pin) begin
      state_nxt = PDMC_HWSTBY;
    end
  end

  // State and counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= PDMC_RUN;
      cnt_r      <= 32'd0;
      init_low_r <= 1'b0;
    end else if (ce) begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      init_low_r <= chip_init;
    end
  end

  // Control registers
  wire wr_ok = req.wr && !chip_init && !hw_hw_power_down_pin;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mstby_r  <= `PDMC_MSTBY_RST;
      sysctl_r <= `PDMC_SYSCTL_RST;
      clkdiv_r <= 2'h0;
    end else if (ce) begin
      if (chip_init || hw_hw_power_down_pin) begin
        mstby_r  <= `PDMC_MSTBY_RST;
        sysctl_r <= `PDMC_SYSCTL_RST;
        clkdiv_r <= 2'h0;
      end else if (wr_ok) begin
        if (sel_mstby) begin
          mstby_r <= req.wdata;
        end
        if (sel_sysctl) begin
          sysctl_r <= req.wdata;
        end
        if (sel_clkdiv) begin
          clkdiv_r <= req.wdata[1:0];
        end
      end
    end
  end

  // Read data one cycle after strobe
  wire [7:0] status_val = {5'h0, state_r};
  wire [7:0] rd_mux = sel_mstby  ? mstby_r :
                      sel_sysctl ? sysctl_r :
                      sel_clkdiv ? {6'h0, clkdiv_r} :
                      sel_status ? status_val : 8'h00;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= req.rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Module halts: register bits act from the cycle after the write
  wire in_hw_power_down_pin = (state_r == PDMC_SWSTBY) || (state_r == PDMC_SETTLE) || (state_r == PDMC_HWSTBY);
  assign halt.wide_timer_halt        = mstby_r[`PDMC_BIT_WIDE_TMR] || in_hw_power_down_pin;
  assign halt.byte_timer_pair_a_halt = mstby_r[`PDMC_BIT_PAIR_A] || in_hw_power_down_pin;
  assign halt.byte_timer_pair_b_halt = mstby_r[`PDMC_BIT_PAIR_B] || in_hw_power_down_pin;
  assign halt.converter_halt         = mstby_r[`PDMC_BIT_CONV] || in_hw_power_down_pin;

  // Peripheral access gating
  wire [3:0] halt_vec = {halt.wide_timer_halt, halt.byte_timer_pair_a_halt,
                         halt.byte_timer_pair_b_halt, halt.converter_halt};
  wire       sel_halted = |(periph_sel & halt_vec);
  assign periph_rdata_gated = sel_halted ? 8'hff : periph_rdata;
  assign periph_wr_block    = sel_halted;

  // Chip-level controls
  assign cpu_halt        = state_r != PDMC_RUN;
  assign clock_run       = !((state_r == PDMC_SWSTBY) || (state_r == PDMC_HWSTBY)) || chip_init;
  assign periph_reset    = (state_r == PDMC_SWSTBY) || (state_r == PDMC_HWSTBY);
  assign int_exc_start   = ((state_r == PDMC_SLEEP) && any_wake && !chip_init && !hw_hw_power_down_pin) ||
                           ((state_r == PDMC_SETTLE) && (cnt_r >= wait_tgt) && !chip_init && !hw_hw_power_down_pin);
  assign reset_exc_start = init_low_r && !chip_init && !hw_hw_power_down_pin;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_mstby_clear_init: assert property (@(posedge clk) disable iff (!rstn)
    (ce && chip_init) |=> mstby_r == 8'h00) else $error("standby reg not cleared");
  a_wide_halt_bit: assert property (@(posedge clk) disable iff (!rstn)
    (ce && wr_ok && sel_mstby && req.wdata[4]) |=> halt.wide_timer_halt)
    else $error("wide timer not halted");
  a_pair_a_bit: assert property (@(posedge clk) disable iff (!rstn)
    (ce && wr_ok && sel_mstby && req.wdata[3]) |=> halt.byte_timer_pair_a_halt)
    else $error("pair a not halted");
  a_pair_b_bit: assert property (@(posedge clk) disable iff (!rstn)
    (ce && wr_ok && sel_mstby && req.wdata[2]) |=> halt.byte_timer_pair_b_halt)
    else $error("pair b not halted");
  a_conv_halt_bit: assert property (@(posedge clk) disable iff (!rstn)
    (ce && wr_ok && sel_mstby && req.wdata[0]) |=> halt.converter_halt)
    else $error("converter not halted");
  a_reserved_readback: assert property (@(posedge clk) disable iff (!rstn)
    (ce && wr_ok && sel_mstby) ##1 (ce && req.rd && sel_mstby && !req.wr && !chip_init && !hw_hw_power_down_pin)
    |=> rdata == $past(req.wdata, 2)) else $error("standby readback wrong");
  a_sleep_entry: assert property (@(posedge clk) disable iff (!rstn)
    (ce && state_r == PDMC_RUN && sleep_exec && !ssel && !chip_init && !hw_hw_power_down_pin)
    |=> state_r == PDMC_SLEEP && cpu_halt) else $error("sleep not entered");
  a_sleep_runs: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == PDMC_SLEEP && !mstby_r[0]) |-> !halt.converter_halt)
    else $error("converter halted in sleep");
  a_sleep_wake: assert property (@(posedge clk) disable iff (!rstn)
    (ce && state_r == PDMC_SLEEP && any_wake && !hw_hw_power_down_pin) |=> state_r == PDMC_RUN)
    else $error("sleep not ended");
  a_hw_hw_power_down_pin_entry: assert property (@(posedge clk) disable iff (!rstn)
    (ce && hw_hw_power_down_pin) |=> state_r == PDMC_HWSTBY) else $error("hw standby missed");
  a_swstby_entry: assert property (@(posedge clk) disable iff (!rstn)
    (ce && state_r == PDMC_RUN && sleep_exec && ssel && !chip_init && !hw_hw_power_down_pin)
    |=> periph_reset && !clock_run) else $error("sw standby not entered");
  a_masked_no_wake: assert property (@(posedge clk) disable iff (!rstn)
    (ce && state_r == PDMC_SWSTBY && !nmi_req && irq_cpu_mask && !chip_init && !hw_hw_power_down_pin)
    |=> state_r == PDMC_SWSTBY) else $error("masked irq woke");
  a_settle_hold: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == PDMC_SETTLE && cnt_r < wait_tgt) |-> cpu_halt && !int_exc_start)
    else $error("left settle early");
  a_settle_wake: assert property (@(posedge clk) disable iff (!rstn)
    (ce && state_r == PDMC_SWSTBY && nmi_req && !chip_init && !hw_hw_power_down_pin)
    |=> state_r == PDMC_SETTLE && cnt_r == 32'd1) else $error("nmi did not wake");
  a_init_clock: assert property (@(posedge clk) disable iff (!rstn)
    chip_init |-> clock_run) else $error("clock not run on init");

  c_sleep_cycle: cover property (@(posedge clk) disable iff (!rstn)
    state_r == PDMC_SLEEP ##[1:20] state_r == PDMC_RUN);
  c_swstby_wake: cover property (@(posedge clk) disable iff (!rstn)
    state_r == PDMC_SETTLE ##1 state_r == PDMC_RUN);
  c_hw_hw_power_down_pin: cover property (@(posedge clk) disable iff (!rstn) state_r == PDMC_HWSTBY);
  c_gated_read: cover property (@(posedge clk) disable iff (!rstn) sel_halted);
endmodule
`default_nettype wire

// *** hdl/pdmc_params.svh ***
`ifndef PDMC_PARAMS_SVH
`define PDMC_PARAMS_SVH
// Register indices on the plain register port
`define PDMC_ADDR_MSTBY      4'h0
`define PDMC_ADDR_SYSCTL     4'h1
`define PDMC_ADDR_CLKDIV     4'h2
`define PDMC_ADDR_STATUS     4'h3
// Reset values
`define PDMC_MSTBY_RST       8'h00
`define PDMC_SYSCTL_RST      8'h00
`define PDMC_CLKDIV_RST      8'h00
// Module standby field positions
`define PDMC_BIT_WIDE_TMR    4
`define PDMC_BIT_PAIR_A      3
`define PDMC_BIT_PAIR_B      2
`define PDMC_BIT_CONV        0
// System control field positions
`define PDMC_BIT_SSEL        7
`define PDMC_STS_HI          6
`define PDMC_STS_LO          4
// Settling wait base counts in states
`define PDMC_WAIT_0          32'd8192
`define PDMC_WAIT_1          32'd16384
`define PDMC_WAIT_2          32'd32768
`define PDMC_WAIT_3          32'd65536
`define PDMC_WAIT_4          32'd131072
`define PDMC_WAIT_5          32'd262144
`define PDMC_WAIT_6          32'd1024
`endif

// *** hdl/pdmc_pkg.sv ***
package pdmc_pkg;
  // Power state of the chip
  typedef enum logic [2:0] {
    PDMC_RUN,
    PDMC_SLEEP,
    PDMC_SWSTBY,
    PDMC_SETTLE,
    PDMC_HWSTBY
  } pdmc_state_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pdmc_req_t;

  // Module standby strobes
  typedef struct packed {
    logic wide_timer_halt;
    logic byte_timer_pair_a_halt;
    logic byte_timer_pair_b_halt;
    logic converter_halt;
  } pdmc_halt_t;
endpackage

// *** sim/tb_pdmc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_params.svh"
module tb_pdmc_ctrl;
  import pdmc_pkg::*;
  localparam int         SCALE = 256;
  localparam logic [3:0] A_MS  = `PDMC_ADDR_MSTBY;
  localparam logic [3:0] A_SC  = `PDMC_ADDR_SYSCTL;
  localparam logic [3:0] A_CD  = `PDMC_ADDR_CLKDIV;
  localparam logic [3:0] A_ST  = `PDMC_ADDR_STATUS;
  localparam int         BASE [8] = '{8192, 16384, 32768, 65536, 131072, 262144, 1024, 262144};
  logic       clk, rstn, init_n, hwpd_n, sleep_exec, nmi_req, irq_cpu_mask, periph_int_req;
  logic       cpu_halt, int_exc_start, reset_exc_start, clock_run, periph_reset, periph_wr_block;
  logic [2:0] irq_req, irq_enable;
  logic [3:0] periph_sel;
  logic [7:0] rdata, periph_rdata, periph_rdata_gated, v;
  pdmc_req_t  req;
  pdmc_halt_t halt;
  int         n_mismatch, checked, n, c, d;
  logic [7:0] pats [6] = '{8'h10, 8'h08, 8'h04, 8'h01, 8'he2, 8'hff};

  pdmc_ctrl #(.WAIT_SCALE(SCALE)) i_dut (.clk(clk), .rstn(rstn), .ce(1'b1), .req(req), .rdata(rdata),
    .chip_init_pin_n(init_n), .hw_power_down_pin_n(hwpd_n), .sleep_exec(sleep_exec), .nmi_req(nmi_req),
    .irq_req(irq_req), .irq_enable(irq_enable), .irq_cpu_mask(irq_cpu_mask), .periph_int_req(periph_int_req),
    .cpu_halt(cpu_halt), .int_exc_start(int_exc_start), .reset_exc_start(reset_exc_start),
    .clock_run(clock_run), .periph_reset(periph_reset), .periph_sel(periph_sel), .periph_rdata(periph_rdata),
    .periph_rdata_gated(periph_rdata_gated), .periph_wr_block(periph_wr_block), .halt(halt));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Comparison and verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Register port cycles, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge clk);
    req <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    #2;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #2;
    chk(nm, 32'(rdata), 32'(e));
  endtask

  // Sleep instruction pulse and bounded wait for the wake pulse
  task automatic do_sleep();
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    #2;
  endtask
  task automatic wait_exc(input int lim);
    n = 0;
    while (int_exc_start !== 1'b1) begin
      @(posedge clk);
      #2;
      n++;
      if (n > lim) begin
        n_mismatch++;
        give_verdict();
      end
    end
  endtask
  task automatic hold_chk(input string nm);
    repeat (12) @(posedge clk);
    #2;
    chk(nm, 32'(cpu_halt), 32'h1);
  endtask

  // Leave any standby through the init pin, init pin low before the power-down pin rises
  task automatic pin_exit();
    @(posedge clk);
    init_n <= 1'b0;
    @(posedge clk);
    hwpd_n <= 1'b1;
    #2;
    chk("clock_run", 32'(clock_run), 32'h1);
    @(posedge clk);
    init_n <= 1'b1;
    #2;
    chk("reset_exc", 32'(reset_exc_start), 32'h1);
    rchk("status", A_ST, 8'h00);
    rchk("mstby", A_MS, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_mismatch = 0;
    checked = 0;
    rstn = 1'b0;
    req = '0;
    {init_n, hwpd_n, sleep_exec, nmi_req, irq_cpu_mask, periph_int_req} = 6'b110000;
    {irq_req, irq_enable, periph_sel, periph_rdata} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rchk("mstby", A_MS, 8'h00);
    chk("halt", 32'(halt), 32'h0);
    chk("clock_run", 32'(clock_run), 32'h1);
    foreach (pats[i]) begin
      wr(A_MS, pats[i]);
      chk("halt", 32'(halt), 32'({pats[i][4], pats[i][3], pats[i][2], pats[i][0]}));
      rchk("mstby", A_MS, pats[i]);
    end
    wr(4'h9, 8'h5a);
    rchk("unmapped", 4'h9, 8'h00);
    wr(A_MS, 8'h10);
    @(posedge clk);
    {periph_sel, periph_rdata} <= {4'b1000, 8'h5a};
    #2;
    chk("gated", 32'({periph_wr_block, periph_rdata_gated}), 32'h1ff);
    @(posedge clk);
    periph_sel <= 4'b0100;
    #2;
    chk("gated", 32'({periph_wr_block, periph_rdata_gated}), 32'h05a);
    // Sleep: masked sources hold it, an unmasked one ends it
    wr(A_SC, 8'h00);
    do_sleep();
    chk("sleep", 32'({cpu_halt, clock_run, halt}), 32'h38);
    rchk("status", A_ST, 8'h01);
    @(posedge clk);
    {irq_req, irq_enable, irq_cpu_mask, periph_int_req} <= 8'b001_111_1_1;
    hold_chk("masked");
    @(posedge clk);
    irq_cpu_mask <= 1'b0;
    #2;
    wait_exc(4);
    @(posedge clk);
    {irq_req, periph_int_req} <= '0;
    #2;
    chk("cpu_halt", 32'(cpu_halt), 32'h0);
    do_sleep();
    @(posedge clk);
    init_n <= 1'b0;
    @(posedge clk);
    #2;
    chk("cpu_halt", 32'(cpu_halt), 32'h0);
    pin_exit();
    wr(A_MS, 8'h10);
    do_sleep();
    @(posedge clk);
    hwpd_n <= 1'b0;
    rchk("status", A_ST, 8'h04);
    pin_exit();
    // Software standby: every settle code, divider steps, wake count
    wr(A_MS, 8'h05);
    for (int i = 0; i < 11; i++) begin
      c = (i < 8) ? i : 6;
      d = (i < 8) ? 0 : i - 7;
      wr(A_SC, {1'b1, 3'(c), 4'h0});
      wr(A_CD, {6'h00, 2'(d)});
      do_sleep();
      chk("swstby", 32'({clock_run, periph_reset, halt}), 32'h1f);
      if (i == 0) begin
        @(posedge clk);
        {irq_req, irq_enable} <= {3'b111, 3'b000};
        hold_chk("irq_off");
        @(posedge clk);
        {irq_enable, irq_cpu_mask} <= 4'b111_1;
        hold_chk("irq_mask");
        @(posedge clk);
        {irq_req, irq_enable, irq_cpu_mask} <= '0;
      end
      @(posedge clk);
      if (i % 2 == 0)
        nmi_req <= 1'b1;
      else
        {irq_req, irq_enable} <= {3'(1 << (i % 3)), 3'b111};
      #2;
      wait_exc(9000);
      chk("settle", 32'(n), 32'((BASE[c] << d) / SCALE));
      @(posedge clk);
      {nmi_req, irq_req} <= '0;
      rchk("sysctl", A_SC, {1'b1, 3'(c), 4'h0});
    end
    rchk("mstby", A_MS, 8'h05);
    do_sleep();
    @(posedge clk);
    hwpd_n <= 1'b0;
    rchk("status", A_ST, 8'h04);
    pin_exit();
    give_verdict();
  end
endmodule
`default_nettype wire
